/* afe_cutoff_map.sv */
// cut-off decode: register codes to corner frequencies
`timescale 1ns/1ns
module afe_cutoff_map (
   input  wire logic [1:0] hp_code_i,   // high-pass select code
   input  wire logic [1:0] lp_code_i,   // low-pass select code
   input  wire logic       economy_i,   // economy mode halves the low-pass corner
   output logic      [9:0] hp_khz_o,    // high-pass corner, kHz
   output logic      [7:0] lp_100k_o    // low-pass corner, units of 100 kHz
);
   logic [7:0] lp_full; // corner before economy halving

   // high-pass table
   always_comb begin
      case (hp_code_i)
         2'h0:    hp_khz_o = afe_regs_pkg::HP_KHZ_00;
         2'h1:    hp_khz_o = afe_regs_pkg::HP_KHZ_01;
         2'h2:    hp_khz_o = afe_regs_pkg::HP_KHZ_10;
         default: hp_khz_o = afe_regs_pkg::HP_KHZ_11;
      endcase
   end

   // low-pass table, halved in economy mode
   always_comb begin
      case (lp_code_i)
         2'h0:    lp_full = afe_regs_pkg::LP_KHZ100_00;
         2'h1:    lp_full = afe_regs_pkg::LP_KHZ100_01;
         2'h2:    lp_full = afe_regs_pkg::LP_KHZ100_10;
         default: lp_full = afe_regs_pkg::LP_KHZ100_11;
      endcase
      lp_100k_o = economy_i ? {1'b0, lp_full[7:1]} : lp_full;
   end
endmodule // afe_cutoff_map

/* afe_regs_pkg.sv */
// package: register offsets, field positions and output carrier for the analog control bank
package afe_regs_pkg;
   localparam logic [7:0]  CHAN_PD_OFS      = 8'hc5;   // channel power-down word
   localparam logic [7:0]  BLOCK_PD_OFS     = 8'hc6;   // block power-down word
   localparam logic [7:0]  FILTER_CFG_OFS   = 8'hc7;   // filter configuration word
   localparam logic [7:0]  POWER_MODE_OFS   = 8'hc8;   // power-mode word
   localparam logic [15:0] RESET_VALUE      = 16'h0000; // every word resets to zero
   localparam int          NUM_CHAN         = 10;      // channels served by this bank
   localparam int          QUICK_BIT        = 0;
   localparam int          FULL_BIT         = 1;
   localparam int          AMP_BIT          = 2;
   localparam int          LOWPASS_BIT      = 3;
   localparam int          HP_SEL_LSB       = 10;
   localparam int          HP_SEL_MSB       = 11;
   localparam int          HP_OFF_BIT       = 9;
   localparam int          LP_SEL_LSB       = 7;
   localparam int          LP_SEL_MSB       = 8;
   localparam int          ECONOMY_BIT      = 12;
   // low-pass corner in units of 100 kHz, normal mode; economy halves it
   localparam logic [7:0]  LP_KHZ100_00     = 8'h96;   // 15 MHz
   localparam logic [7:0]  LP_KHZ100_01     = 8'h64;   // 10 MHz
   localparam logic [7:0]  LP_KHZ100_10     = 8'hfa;   // 25 MHz
   localparam logic [7:0]  LP_KHZ100_11     = 8'hc8;   // 20 MHz
   // high-pass corner in kHz
   localparam logic [9:0]  HP_KHZ_00        = 10'h04b; // 75 kHz
   localparam logic [9:0]  HP_KHZ_01        = 10'h096; // 150 kHz
   localparam logic [9:0]  HP_KHZ_10        = 10'h12c; // 300 kHz
   localparam logic [9:0]  HP_KHZ_11        = 10'h258; // 600 kHz

   // per-block analog enables that leave the bank
   typedef struct packed {
      logic [NUM_CHAN-1:0] amp_on;      // amplifier enable per channel
      logic [NUM_CHAN-1:0] lowpass_on;  // low-pass filter enable per channel
      logic [NUM_CHAN-1:0] mixer_on;    // mixer enable per channel
      logic                gain_eng_on; // gain-control engine enable
      logic                quick_sleep; // partial bias-down, fast wake
      logic                highpass_on; // amplifier high-pass in circuit
   } analog_ctl_s;
endpackage

/* analog_chain_power_filter_regs.sv */
// register bank: channel and block power-down plus filter corner selection
//
// How it works
// [RULE1] channel bit n powers off channel n+1
// [RULE2] channel bit never touches converter
// [RULE3] bit 3 powers off low-pass filter
// [RULE4] bit 2 powers off amplifier
// [RULE5] bit 1 full shutdown, slow wake
// [RULE6] bit 0 quick shutdown, fast wake
// [RULE7] shutdowns leave the converter running
// [RULE8] bits 11-10 pick high-pass corner
// [RULE9] bit 9 takes high-pass out
// [RULE10] code 00: 15 MHz, economy 7.5
// [RULE11] code 01: 10 MHz, economy 5
// [RULE12] code 10: 25/12.5, code 11: 20/10
// [RULE13] economy halves corners only in time-gain mode
// [RULE14] unused bits stored and read back
`timescale 1ns/1ns
module analog_chain_power_filter_regs (
   input  wire logic                      CORE_CLK_I,    // 10 MHz register clock
   input  wire logic                      ARST_N_I,      // asynchronous reset, low active
   input  wire logic [7:0]                ADDR_I,        // register address
   input  wire logic [15:0]               WDATA_I,       // write data
   input  wire logic                      WR_I,          // write strobe
   input  wire logic                      RD_I,          // read strobe
   input  wire logic                      CW_MODE_I,     // high while continuous-wave mode
   output logic      [15:0]               RDATA_O,       // read data, cycle after strobe
   output afe_regs_pkg::analog_ctl_s      ANALOG_CTL_O,  // analog enables
   output logic      [9:0]                HP_KHZ_O,      // high-pass corner, kHz
   output logic      [7:0]                LP_100K_O,     // low-pass corner, 100 kHz units
   output logic                           CONV_ON_O      // converter enable, always on
);
   logic [15:0] chan_power_down_reg;        // channel power-down word
   logic [15:0] analog_block_power_down_reg; // block power-down word
   logic [15:0] analog_filter_config_reg;   // filter configuration word
   logic [15:0] power_mode_reg;             // power-mode word (economy bit)
   logic [15:0] rdata_next;                 // read mux result
   logic        economy_eff;                // economy active now
   logic [9:0]  hp_khz;                     // decoded high-pass
   logic [7:0]  lp_100k;                    // decoded low-pass
   afe_regs_pkg::analog_ctl_s ctl_next;     // enables before registering

   // address compare used by write and read paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // channel word, all 16 bits stored [RULE14]
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         chan_power_down_reg <= afe_regs_pkg::RESET_VALUE;
      end else if (WR_I && hit(ADDR_I, afe_regs_pkg::CHAN_PD_OFS)) begin
         chan_power_down_reg <= WDATA_I; // [RULE1]
      end
   end

   // block power-down word, unused bits kept [RULE14]
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         analog_block_power_down_reg <= afe_regs_pkg::RESET_VALUE;
      end else if (WR_I && hit(ADDR_I, afe_regs_pkg::BLOCK_PD_OFS)) begin
         analog_block_power_down_reg <= WDATA_I;
      end
   end

   // filter configuration word [RULE14]
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         analog_filter_config_reg <= afe_regs_pkg::RESET_VALUE;
      end else if (WR_I && hit(ADDR_I, afe_regs_pkg::FILTER_CFG_OFS)) begin
         analog_filter_config_reg <= WDATA_I;
      end
   end

   // power-mode word, holds economy bit
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         power_mode_reg <= afe_regs_pkg::RESET_VALUE;
      end else if (WR_I && hit(ADDR_I, afe_regs_pkg::POWER_MODE_OFS)) begin
         power_mode_reg <= WDATA_I;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rdata_next = '0;
      if (hit(ADDR_I, afe_regs_pkg::CHAN_PD_OFS)) begin
         rdata_next = chan_power_down_reg;
      end else if (hit(ADDR_I, afe_regs_pkg::BLOCK_PD_OFS)) begin
         rdata_next = analog_block_power_down_reg;
      end else if (hit(ADDR_I, afe_regs_pkg::FILTER_CFG_OFS)) begin
         rdata_next = analog_filter_config_reg;
      end else if (hit(ADDR_I, afe_regs_pkg::POWER_MODE_OFS)) begin
         rdata_next = power_mode_reg;
      end
   end

   // read data register, holds value after read
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         RDATA_O <= '0;
      end else if (RD_I) begin
         RDATA_O <= rdata_next;
      end
   end

   // economy applies in time-gain mode only
   assign economy_eff = power_mode_reg[afe_regs_pkg::ECONOMY_BIT] && !CW_MODE_I; // [RULE13]

   // corner decode
   afe_cutoff_map u_cutoff (
      .hp_code_i (analog_filter_config_reg[afe_regs_pkg::HP_SEL_MSB:afe_regs_pkg::HP_SEL_LSB]), // [RULE8]
      .lp_code_i (analog_filter_config_reg[afe_regs_pkg::LP_SEL_MSB:afe_regs_pkg::LP_SEL_LSB]), // [RULE10]
      .economy_i (economy_eff),
      .hp_khz_o  (hp_khz),
      .lp_100k_o (lp_100k)                                                   // [RULE11] [RULE12]
   );

   // enables from the power-down words and the high-pass disable bit
   always_comb begin
      logic full_off;
      logic quick_off;
      logic [afe_regs_pkg::NUM_CHAN-1:0] chan_off;
      full_off  = analog_block_power_down_reg[afe_regs_pkg::FULL_BIT];   // [RULE5]
      quick_off = analog_block_power_down_reg[afe_regs_pkg::QUICK_BIT];  // [RULE6]
      chan_off  = chan_power_down_reg[afe_regs_pkg::NUM_CHAN-1:0];       // [RULE1]
      ctl_next.amp_on      = ~chan_off & {afe_regs_pkg::NUM_CHAN{
                             !(full_off || quick_off || analog_block_power_down_reg[afe_regs_pkg::AMP_BIT])}}; // [RULE4]
      ctl_next.lowpass_on  = ~chan_off & {afe_regs_pkg::NUM_CHAN{
                             !(full_off || quick_off || analog_block_power_down_reg[afe_regs_pkg::LOWPASS_BIT])}}; // [RULE3]
      ctl_next.mixer_on    = ~chan_off & {afe_regs_pkg::NUM_CHAN{!(full_off || quick_off)}};
      ctl_next.gain_eng_on = !full_off;                                  // [RULE5]
      ctl_next.quick_sleep = quick_off && !full_off;                     // [RULE6]
      ctl_next.highpass_on = !analog_filter_config_reg[afe_regs_pkg::HP_OFF_BIT]; // [RULE9]
   end

   // registered analog outputs
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ANALOG_CTL_O <= '0;
         HP_KHZ_O     <= '0;
         LP_100K_O    <= '0;
      end else begin
         ANALOG_CTL_O <= ctl_next;
         HP_KHZ_O     <= hp_khz;
         LP_100K_O    <= lp_100k;
      end
   end

   // converter never gated by this bank
   assign CONV_ON_O = 1'b1; // [RULE2] [RULE7]

   // write then read returns same word
   readback_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE14]
      (WR_I && hit(ADDR_I, afe_regs_pkg::FILTER_CFG_OFS)) ##1 (RD_I && hit(ADDR_I, afe_regs_pkg::FILTER_CFG_OFS))
      |=> RDATA_O == $past(WDATA_I, 2)) else $error("filter word readback wrong");
   chan_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE1]
      (WR_I && hit(ADDR_I, afe_regs_pkg::CHAN_PD_OFS) && WDATA_I[0]) |=> ##1 !ANALOG_CTL_O.amp_on[0])
      else $error("channel 1 not off");
   conv_on_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) CONV_ON_O) // [RULE7]
      else $error("converter gated");
   full_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE5]
      analog_block_power_down_reg[afe_regs_pkg::FULL_BIT] |=> !ANALOG_CTL_O.gain_eng_on && ANALOG_CTL_O.mixer_on == '0)
      else $error("full shutdown incomplete");
   quick_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE6]
      (analog_block_power_down_reg[1:0] == 2'h1) |=> ANALOG_CTL_O.quick_sleep && ANALOG_CTL_O.gain_eng_on)
      else $error("quick shutdown wrong");
   amp_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE4]
      analog_block_power_down_reg[afe_regs_pkg::AMP_BIT] |=> ANALOG_CTL_O.amp_on == '0)
      else $error("amplifier not off");
   lp_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE3]
      analog_block_power_down_reg[afe_regs_pkg::LOWPASS_BIT] |=> ANALOG_CTL_O.lowpass_on == '0)
      else $error("low-pass not off");
   hp_sel_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE8]
      (analog_filter_config_reg[11:10] == 2'h3) |=> HP_KHZ_O == afe_regs_pkg::HP_KHZ_11)
      else $error("high-pass corner wrong");
   lp_econ_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE13]
      (analog_filter_config_reg[8:7] == 2'h0 && power_mode_reg[12] && !CW_MODE_I) |=> LP_100K_O == 8'h4b)
      else $error("economy corner wrong");
   hp_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE9]
      analog_filter_config_reg[9] |=> !ANALOG_CTL_O.highpass_on) else $error("high-pass still on");

   // a cleared disable bit keeps the high-pass in circuit
   hp_on_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE9]
      !analog_filter_config_reg[afe_regs_pkg::HP_OFF_BIT] |=> ANALOG_CTL_O.highpass_on)
      else $error("high-pass wrongly off");

   // lowest high-pass code gives the lowest corner
   hp_low_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE8]
      (analog_filter_config_reg[afe_regs_pkg::HP_SEL_MSB:afe_regs_pkg::HP_SEL_LSB] == 2'h0)
      |=> HP_KHZ_O == afe_regs_pkg::HP_KHZ_00)
      else $error("high-pass low corner wrong");

   // a channel bit also takes that channel's mixer down
   chan_mix_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE1]
      chan_power_down_reg[0] |=> !ANALOG_CTL_O.mixer_on[0] && !ANALOG_CTL_O.lowpass_on[0])
      else $error("channel 1 mixer or filter on");

   // clearing every control restores the powered state of channel 1
   chan_back_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE1]
      (!chan_power_down_reg[0] && analog_block_power_down_reg[3:0] == 4'h0)
      |=> ANALOG_CTL_O.amp_on[0] && ANALOG_CTL_O.lowpass_on[0] && ANALOG_CTL_O.mixer_on[0])
      else $error("channel 1 not restored");

   // quick shutdown takes the mixers of every channel down
   quick_mix_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE6]
      analog_block_power_down_reg[afe_regs_pkg::QUICK_BIT] |=> ANALOG_CTL_O.mixer_on == '0)
      else $error("quick shutdown mixer on");

   // without full shutdown the gain engine stays up
   gain_eng_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE5]
      !analog_block_power_down_reg[afe_regs_pkg::FULL_BIT] |=> ANALOG_CTL_O.gain_eng_on)
      else $error("gain engine wrongly off");

   // code 01 in normal mode gives the 10 MHz corner
   lp_norm_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE11]
      (analog_filter_config_reg[afe_regs_pkg::LP_SEL_MSB:afe_regs_pkg::LP_SEL_LSB] == 2'h1 && !economy_eff)
      |=> LP_100K_O == afe_regs_pkg::LP_KHZ100_01)
      else $error("low-pass 10 MHz corner wrong");

   // code 10 in normal mode gives the 25 MHz corner
   lp_top_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE12]
      (analog_filter_config_reg[afe_regs_pkg::LP_SEL_MSB:afe_regs_pkg::LP_SEL_LSB] == 2'h2 && !economy_eff)
      |=> LP_100K_O == afe_regs_pkg::LP_KHZ100_10)
      else $error("low-pass 25 MHz corner wrong");

   // continuous-wave mode ignores the economy bit
   lp_cw_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE13]
      (analog_filter_config_reg[afe_regs_pkg::LP_SEL_MSB:afe_regs_pkg::LP_SEL_LSB] == 2'h0 && CW_MODE_I)
      |=> LP_100K_O == afe_regs_pkg::LP_KHZ100_00)
      else $error("economy applied in wave mode");

   // block word written then read returns the same word
   blk_back_a: assert property (@(posedge CORE_CLK_I) disable iff (!ARST_N_I) // [RULE14]
      (WR_I && hit(ADDR_I, afe_regs_pkg::BLOCK_PD_OFS)) ##1 (RD_I && hit(ADDR_I, afe_regs_pkg::BLOCK_PD_OFS))
      |=> RDATA_O == $past(WDATA_I, 2)) else $error("block word readback wrong");
endmodule // analog_chain_power_filter_regs

/* analog_chain_power_filter_regs_test.sv */
// self-checking testbench for the analog power and filter register bank
`timescale 1ns/1ns
module analog_chain_power_filter_regs_test;
   logic                      CORE_CLK_I = 1'b0;  // 10 MHz clock
   logic                      ARST_N_I;           // reset, low active
   logic [7:0]                ADDR_I;             // register address
   logic [15:0]               WDATA_I;            // write data
   logic                      WR_I;               // write strobe
   logic                      RD_I;               // read strobe
   logic                      CW_MODE_I;          // continuous-wave mode level
   logic [15:0]               RDATA_O;            // read data
   afe_regs_pkg::analog_ctl_s ANALOG_CTL_O;       // analog enables
   logic [9:0]                HP_KHZ_O;           // high-pass corner
   logic [7:0]                LP_100K_O;          // low-pass corner
   logic                      CONV_ON_O;          // converter enable
   int                        err_total = 0;      // mismatches seen
   int                        n_checks = 0;       // comparisons made
   logic [15:0]               ch_m, blk_m, fl_m, pm_m; // bench copies of the words

   analog_chain_power_filter_regs u_dut (.CORE_CLK_I(CORE_CLK_I), .ARST_N_I(ARST_N_I), .ADDR_I(ADDR_I),
      .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .CW_MODE_I(CW_MODE_I), .RDATA_O(RDATA_O),
      .ANALOG_CTL_O(ANALOG_CTL_O), .HP_KHZ_O(HP_KHZ_O), .LP_100K_O(LP_100K_O), .CONV_ON_O(CONV_ON_O));

   // free-running clock, 100 ns period
   initial begin
      forever #50 CORE_CLK_I = ~CORE_CLK_I;
   end

   // verdict and end of run
   task automatic stop_test();
      if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // compare one value, report a mismatch at once
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe, bench copy follows
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge CORE_CLK_I);
      ADDR_I  <= a;
      WDATA_I <= d;
      WR_I    <= 1'b1;
      @(posedge CORE_CLK_I);
      WR_I    <= 1'b0;
      case (a)
         afe_regs_pkg::CHAN_PD_OFS:    ch_m = d;
         afe_regs_pkg::BLOCK_PD_OFS:   blk_m = d;
         afe_regs_pkg::FILTER_CFG_OFS: fl_m = d;
         afe_regs_pkg::POWER_MODE_OFS: pm_m = d;
         default:                      ; // unmapped, nothing stored
      endcase
   endtask

   // one-cycle read strobe, data looked at in the following cycle
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge CORE_CLK_I);
      ADDR_I <= a;
      RD_I   <= 1'b1;
      @(posedge CORE_CLK_I);
      RD_I   <= 1'b0;
      @(negedge CORE_CLK_I);
      chk({24'h0, RDATA_O}, {24'h0, exp});
   endtask

   // expected analog outputs worked out from the bench copies
   task automatic check_all();
      afe_regs_pkg::analog_ctl_s e;
      logic [7:0]                lp;
      logic [9:0]                hp;
      logic                      full;
      @(posedge CORE_CLK_I);
      @(negedge CORE_CLK_I);
      full = blk_m[1];
      e.amp_on      = ~ch_m[9:0] & {10{~blk_m[2] & ~full & ~blk_m[0]}};
      e.lowpass_on  = ~ch_m[9:0] & {10{~blk_m[3] & ~full & ~blk_m[0]}};
      e.mixer_on    = ~ch_m[9:0] & {10{~full & ~blk_m[0]}};
      e.gain_eng_on = ~full;
      e.quick_sleep = blk_m[0] & ~full;
      e.highpass_on = ~fl_m[9];
      case (fl_m[8:7])
         2'h0:    lp = 8'h96;
         2'h1:    lp = 8'h64;
         2'h2:    lp = 8'hfa;
         default: lp = 8'hc8;
      endcase
      if (pm_m[12] && !CW_MODE_I) lp = lp >> 1;
      case (fl_m[11:10])
         2'h0:    hp = 10'h04b;
         2'h1:    hp = 10'h096;
         2'h2:    hp = 10'h12c;
         default: hp = 10'h258;
      endcase
      chk({7'h0, ANALOG_CTL_O}, {7'h0, e});
      chk({30'h0, HP_KHZ_O}, {30'h0, hp});
      chk({32'h0, LP_100K_O}, {32'h0, lp});
      chk({39'h0, CONV_ON_O}, 40'h1);
   endtask

   // main sequence
   initial begin
      ARST_N_I = 1'b0;
      ADDR_I = 8'h00;
      WDATA_I = 16'h0000;
      WR_I = 1'b0;
      RD_I = 1'b0;
      CW_MODE_I = 1'b0;
      {ch_m, blk_m, fl_m, pm_m} = 64'h0;
      repeat (6) @(posedge CORE_CLK_I);
      ARST_N_I <= 1'b1;
      check_all();
      for (int i = 0; i < 5; i++) rd(8'hc5 + 8'(i), 16'h0000);
      for (int n = 0; n < 10; n++) begin
         wr(afe_regs_pkg::CHAN_PD_OFS, 16'h0001 << n);
         check_all();
      end
      wr(afe_regs_pkg::CHAN_PD_OFS, 16'hfc00);
      rd(afe_regs_pkg::CHAN_PD_OFS, 16'hfc00);
      check_all();
      wr(afe_regs_pkg::CHAN_PD_OFS, 16'h0000);
      for (int b = 0; b < 4; b++) begin
         wr(afe_regs_pkg::BLOCK_PD_OFS, 16'h0001 << b);
         check_all();
      end
      wr(afe_regs_pkg::BLOCK_PD_OFS, 16'h0003);
      check_all();
      wr(afe_regs_pkg::BLOCK_PD_OFS, 16'h000f);
      rd(afe_regs_pkg::BLOCK_PD_OFS, 16'h000f);
      check_all();
      wr(afe_regs_pkg::BLOCK_PD_OFS, 16'h0000);
      for (int i = 0; i < 16; i++) begin
         wr(afe_regs_pkg::FILTER_CFG_OFS, {4'h0, 2'(i >> 2), 1'(i), 2'(i), 7'h00});
         check_all();
         rd(afe_regs_pkg::FILTER_CFG_OFS, fl_m);
      end
      wr(afe_regs_pkg::POWER_MODE_OFS, 16'h1000);
      for (int i = 0; i < 8; i++) begin
         wr(afe_regs_pkg::FILTER_CFG_OFS, {7'h00, 2'(i), 7'h00});
         CW_MODE_I <= i[2];
         @(posedge CORE_CLK_I);
         check_all();
      end
      wr(8'hc9, 16'hffff);
      rd(8'hc9, 16'h0000);
      rd(afe_regs_pkg::FILTER_CFG_OFS, fl_m);
      // second reset in mid-run returns every word to zero
      @(posedge CORE_CLK_I);
      ARST_N_I <= 1'b0;
      repeat (2) @(posedge CORE_CLK_I);
      ARST_N_I <= 1'b1;
      {ch_m, blk_m, fl_m, pm_m} = 64'h0;
      check_all();
      rd(afe_regs_pkg::BLOCK_PD_OFS, 16'h0000);
      stop_test();
   end

   // watchdog, well beyond the few hundred cycles the tests need
   initial begin
      #200000;
      err_total++;
      stop_test();
   end
endmodule // analog_chain_power_filter_regs_test
